// *** verilog/sfc_top.sv ***
// Flat field shading correction: pixel path, data store, APB slave
//
// Functional notes
// - Corrected level is original over flat level
// - Build request captures next single frame
// - Flat grid expanded by bilinear interpolation
// - Correction applied only while enable is on
// - Sixteen flat slots chosen by slot select
// - Generated data volatile, lost at reset
// - Store copies active data into selected slot
// - Recall copies selected slot into active store
// - Boot slot setting ranges zero to fifteen
// - Gain build values active at once, volatile
// - Gain store overwrites selected gain slot
// - Gain recall replaces active gain values
// - Gain slots: default plus one to seven
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Small output FIFO
// ------------------------------------------------------------------
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp; // Write pointer
    logic [AW-1:0] rp; // Read pointer
    logic [AW:0] cnt; // Words held
    logic room; // Space for one more word
    logic nemp; // At least one word held
  } sfc_fifo_s;
  sfc_fifo_s cur_ff, nxt_ff;
  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
  logic push, pop;

  // Flags are registered, so the handshake ports come from flip-flops
  assign in_ready = cur_ff.room;
  assign out_valid = cur_ff.nemp;
  assign out_data = mem[cur_ff.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    nxt_ff = cur_ff;
    if (push) begin
      nxt_ff.wp = cur_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_ff.rp = cur_ff.rp + 1'b1;
    end
    nxt_ff.cnt = cur_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_ff.room = (nxt_ff.cnt != (AW+1)'(DEPTH));
    nxt_ff.nemp = (nxt_ff.cnt != '0);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.room <= 1'b1; // Empty buffer accepts at once
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Data storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[cur_ff.wp] <= in_data;
    end
  end
endmodule // sfc_fifo

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module sfc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pix_in_valid,
  output logic pix_in_ready,
  input wire logic pix_in_sof,
  input wire logic [7:0] pix_in_data,
  output logic pix_out_valid,
  input wire logic pix_out_ready,
  output logic [7:0] pix_out_data
);
  typedef logic [sfc_pkg::KN-1:0][7:0] sfc_set_t;
  typedef struct packed {
    logic pready; // APB answer
    logic [31:0] prdata;
    logic pslverr;
    logic en; // shading_fix_enable
    logic [3:0] sel; // shading_slot_select
    logic [3:0] boot; // shading_boot_slot
    logic [2:0] gsel; // gain_map_slot_select
    logic bld; // Shading build armed
    logic gbld; // Gain build armed
    logic grab; // Shading capture in this frame
    logic ggrab; // Gain capture in this frame
    logic [5:0] x; // Next pixel column
    logic [4:0] y; // Next pixel row
    sfc_pkg::sfc_op_e op; // Copy engine operation
    logic [3:0] cslot; // Slot latched for the copy
    logic [3:0] cidx; // Knot being copied
    sfc_set_t act; // Active flat data
    sfc_set_t gain; // Active gain values
    logic s1_v;
    logic [7:0] s1_pix;
    logic [3:0] s1_fx, s1_fy;
    logic [3:0] s1_k; // Upper left knot
    logic s2_v;
    logic [7:0] s2_pix, s2_ff;
    logic s3_v;
    logic [7:0] s3_pix;
  } sfc_regs_s;

  sfc_regs_s cur_ff, nxt_ff;
  sfc_set_t shd_nvm [sfc_pkg::SHD_SLOTS]; // Slots, survive reset
  sfc_set_t gain_nvm [sfc_pkg::GAIN_SLOTS]; // Slot 0 factory default
  logic adv; // Pipeline may advance
  logic shd_we, gain_we; // Slot write strobes

  // Knot index from grid coordinates
  function automatic logic [3:0] knot_idx(input logic [2:0] kx,
                                          input logic [1:0] ky);
    knot_idx = 4'(ky * sfc_pkg::GW + kx);
  endfunction

  // Grid coordinate of a knot sitting on this position, else invalid
  function automatic logic [3:0] knot_pos(input logic [5:0] p,
                                          input int last, input int n);
    if (p[3:0] == 4'h0) begin
      knot_pos = {1'b1, 3'(p >> 4)};
    end else if (int'(p) == last) begin
      knot_pos = {1'b1, 3'(n - 1)};
    end else begin
      knot_pos = 4'h0;
    end
  endfunction

  // Linear blend of two levels, weight out of sixteen
  function automatic logic [11:0] blend(input logic [11:0] a,
                                        input logic [11:0] b,
                                        input logic [3:0] f);
    logic [16:0] s;
    s = 17'(a) * 17'(5'd16 - 5'(f)) + 17'(b) * 17'(f);
    blend = s[15:4];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic acc, wr, rd_ok, sof_take, take, bset, gset;
    logic [5:0] cx;
    logic [4:0] cy;
    logic [3:0] kxp, kyp;
    logic [11:0] top, bot, mix;
    logic [14:0] quo;
    logic [31:0] rd;
    nxt_ff = cur_ff;
    acc = psel & ~penable & ~cur_ff.pready;
    wr = psel & penable & cur_ff.pready & pwrite;
    rd_ok = 1'b1;
    rd = '0;
    take = pix_in_valid & adv;
    sof_take = take & pix_in_sof;
    // Build commands at this edge; they win over the frame start clear
    bset = wr && paddr[7:0] == sfc_pkg::REG_CMD &&
           pwdata[sfc_pkg::CMD_BUILD];
    gset = wr && paddr[7:0] == sfc_pkg::REG_CMD &&
           pwdata[sfc_pkg::CMD_GBUILD];
    cx = pix_in_sof ? 6'h0 : cur_ff.x;
    cy = pix_in_sof ? 5'h0 : cur_ff.y;
    kxp = knot_pos(cx, sfc_pkg::IMG_W - 1, sfc_pkg::GW);
    kyp = knot_pos(6'(cy), sfc_pkg::IMG_H - 1, sfc_pkg::GH);
    top = '0;
    bot = '0;
    mix = '0;
    quo = '0;
    shd_we = 1'b0;
    gain_we = 1'b0;

    // APB answers one cycle after setup, in the first access cycle, so no access waits
    nxt_ff.pready = acc;
    if (acc) begin
      unique case (paddr[7:0])
        sfc_pkg::REG_CTRL: begin
          rd[sfc_pkg::CTRL_EN] = cur_ff.en;
          rd[sfc_pkg::CTRL_SEL +: 4] = cur_ff.sel;
          rd[sfc_pkg::CTRL_BOOT +: 4] = cur_ff.boot;
          rd[sfc_pkg::CTRL_GSEL +: 3] = cur_ff.gsel;
        end
        sfc_pkg::REG_CMD: begin
          rd = '0;
        end
        sfc_pkg::REG_STAT: begin
          rd[sfc_pkg::ST_BUSY] = (cur_ff.op != sfc_pkg::OP_IDLE);
          rd[sfc_pkg::ST_BLD] = cur_ff.bld | cur_ff.grab;
          rd[sfc_pkg::ST_GBLD] = cur_ff.gbld | cur_ff.ggrab;
        end
        default: begin
          rd_ok = 1'b0;
        end
      endcase
      nxt_ff.prdata = pwrite ? 32'h0 : rd;
      nxt_ff.pslverr = ~rd_ok;
    end

    // Settings written at the completing edge
    if (wr && paddr[7:0] == sfc_pkg::REG_CTRL) begin
      nxt_ff.en = pwdata[sfc_pkg::CTRL_EN];
      nxt_ff.sel = pwdata[sfc_pkg::CTRL_SEL +: 4];
      nxt_ff.boot = pwdata[sfc_pkg::CTRL_BOOT +: 4];
      nxt_ff.gsel = pwdata[sfc_pkg::CTRL_GSEL +: 3];
    end

    // Build arming; the frame start below may consume the flag
    if (wr && paddr[7:0] == sfc_pkg::REG_CMD) begin
      if (pwdata[sfc_pkg::CMD_BUILD]) begin
        nxt_ff.bld = 1'b1;
      end
      if (pwdata[sfc_pkg::CMD_GBUILD]) begin
        nxt_ff.gbld = 1'b1;
      end
      // Copies are refused while one is still running
      if (cur_ff.op == sfc_pkg::OP_IDLE) begin
        nxt_ff.cidx = '0;
        if (pwdata[sfc_pkg::CMD_STORE]) begin
          nxt_ff.op = sfc_pkg::OP_SHD_ST;
          nxt_ff.cslot = cur_ff.sel;
        end else if (pwdata[sfc_pkg::CMD_RECALL]) begin
          nxt_ff.op = sfc_pkg::OP_SHD_LD;
          nxt_ff.cslot = cur_ff.sel;
        end else if (pwdata[sfc_pkg::CMD_GSTORE]) begin
          nxt_ff.op = sfc_pkg::OP_GN_ST;
          nxt_ff.cslot = {1'b0, cur_ff.gsel};
        end else if (pwdata[sfc_pkg::CMD_GRECALL]) begin
          nxt_ff.op = sfc_pkg::OP_GN_LD;
          nxt_ff.cslot = {1'b0, cur_ff.gsel};
        end
      end
    end

    // Copy engine moves one knot per cycle
    unique case (cur_ff.op)
      sfc_pkg::OP_IDLE: begin
      end
      sfc_pkg::OP_SHD_ST: begin
        shd_we = 1'b1;
      end
      sfc_pkg::OP_SHD_LD: begin
        nxt_ff.act[cur_ff.cidx] = shd_nvm[cur_ff.cslot][cur_ff.cidx];
      end
      sfc_pkg::OP_GN_ST: begin
        gain_we = 1'b1;
      end
      sfc_pkg::OP_GN_LD: begin
        nxt_ff.gain[cur_ff.cidx] =
          gain_nvm[cur_ff.cslot[2:0]][cur_ff.cidx];
      end
    endcase
    if (cur_ff.op != sfc_pkg::OP_IDLE) begin
      nxt_ff.cidx = cur_ff.cidx + 4'h1;
      if (cur_ff.cidx == 4'(sfc_pkg::KN - 1)) begin
        nxt_ff.op = sfc_pkg::OP_IDLE;
      end
    end

    // Frame position and capture of knot samples
    if (take) begin
      nxt_ff.x = (cx == 6'(sfc_pkg::IMG_W - 1)) ? 6'h0 : cx + 6'h1;
      nxt_ff.y = (cx == 6'(sfc_pkg::IMG_W - 1)) ? cy + 5'h1 : cy;
      if (sof_take) begin
        nxt_ff.grab = cur_ff.bld;
        nxt_ff.ggrab = cur_ff.gbld;
        nxt_ff.bld = bset;
        nxt_ff.gbld = gset;
      end
      // Only one frame is sampled: the flag drops after its last pixel
      if ((pix_in_sof ? cur_ff.bld : cur_ff.grab) && kxp[3] && kyp[3]) begin
        nxt_ff.act[knot_idx(kxp[2:0], kyp[1:0])] = pix_in_data;
      end
      if ((pix_in_sof ? cur_ff.gbld : cur_ff.ggrab) && kxp[3] && kyp[3]) begin
        nxt_ff.gain[knot_idx(kxp[2:0], kyp[1:0])] = pix_in_data;
      end
      if (cx == 6'(sfc_pkg::IMG_W - 1) && cy == 5'(sfc_pkg::IMG_H - 1)) begin
        nxt_ff.grab = 1'b0;
        nxt_ff.ggrab = 1'b0;
      end
    end

    // Pixel pipeline, all three stages stall together
    if (adv) begin
      nxt_ff.s1_v = take;
      nxt_ff.s1_pix = pix_in_data;
      nxt_ff.s1_fx = cx[3:0];
      nxt_ff.s1_fy = cy[3:0];
      nxt_ff.s1_k = knot_idx(3'(cx >> 4), 2'(cy >> 4));
      // Bilinear expansion of the four surrounding knots
      top = blend({cur_ff.act[cur_ff.s1_k], 4'h0},
                  {cur_ff.act[cur_ff.s1_k + 4'h1], 4'h0},
                  cur_ff.s1_fx);
      bot = blend({cur_ff.act[cur_ff.s1_k + 4'(sfc_pkg::GW)], 4'h0},
                  {cur_ff.act[cur_ff.s1_k + 4'(sfc_pkg::GW + 1)], 4'h0},
                  cur_ff.s1_fx);
      mix = blend(top, bot, cur_ff.s1_fy);
      nxt_ff.s2_v = cur_ff.s1_v;
      nxt_ff.s2_pix = cur_ff.s1_pix;
      nxt_ff.s2_ff = mix[11:4];
      // Divide stage; bypass goes through it too, same latency
      nxt_ff.s3_v = cur_ff.s2_v;
      quo = 15'({cur_ff.s2_pix, 7'h0} / {7'h0, cur_ff.s2_ff});
      if (!cur_ff.en || cur_ff.s2_ff == 8'h0) begin
        nxt_ff.s3_pix = cur_ff.s2_pix;
      end else if (quo > 15'(sfc_pkg::PIX_MAX)) begin
        nxt_ff.s3_pix = sfc_pkg::PIX_MAX;
      end else begin
        nxt_ff.s3_pix = quo[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; flat data reset to unity, so unsaved data is lost
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.act <= {sfc_pkg::KN{sfc_pkg::FF_UNITY}};
      cur_ff.gain <= {sfc_pkg::KN{sfc_pkg::FF_UNITY}};
      cur_ff.sel <= sfc_pkg::CTRL_RST[sfc_pkg::CTRL_SEL +: 4];
      cur_ff.boot <= sfc_pkg::CTRL_RST[sfc_pkg::CTRL_BOOT +: 4];
      cur_ff.op <= sfc_pkg::OP_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Slot stores; no reset, they stand for non-volatile memory
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (shd_we) begin
      shd_nvm[cur_ff.cslot][cur_ff.cidx] <= cur_ff.act[cur_ff.cidx];
    end
    if (gain_we) begin
      gain_nvm[cur_ff.cslot[2:0]][cur_ff.cidx] <=
        cur_ff.gain[cur_ff.cidx];
    end
  end

  // ----------------------------------------------------------------
  // Output buffer; a full buffer stalls the pipe and the source
  // ----------------------------------------------------------------
  sfc_fifo #(.WIDTH(sfc_pkg::PW), .DEPTH(sfc_pkg::FIFO_D)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(cur_ff.s3_v),
    .in_ready(adv),
    .in_data(cur_ff.s3_pix),
    .out_valid(pix_out_valid),
    .out_ready(pix_out_ready),
    .out_data(pix_out_data)
  );

  assign pix_in_ready = adv;
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
endmodule // sfc_top
`default_nettype wire

// *** verilog/sfc_pkg.sv ***
// Constants and types shared by the shading correction block
package sfc_pkg;
  // ----------------------------------------------------------------
  // Image and knot grid geometry
  // ----------------------------------------------------------------
  localparam int IMG_W = 64; // Pixels per line
  localparam int IMG_H = 32; // Lines per frame
  localparam int CELL = 16; // Pixels between two knots
  localparam int GW = 5; // Knots per row
  localparam int GH = 3; // Knot rows
  localparam int KN = GW * GH; // Knots in one data set
  localparam int PW = 8; // Pixel width
  localparam logic [7:0] FF_UNITY = 8'h80; // Flat level meaning gain 1
  localparam logic [7:0] PIX_MAX = 8'hFF; // Saturation level
  localparam int SHD_SLOTS = 16; // Non-volatile shading slots
  localparam int GAIN_SLOTS = 8; // Gain slots, 0 is factory default
  localparam int FIFO_D = 4; // Output buffer depth
  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // Settings
  localparam logic [7:0] REG_CMD = 8'h04; // Write-one command pulses
  localparam logic [7:0] REG_STAT = 8'h08; // Read-only state
  localparam int CTRL_EN = 0; // shading_fix_enable
  localparam int CTRL_SEL = 4; // shading_slot_select, 4 bits
  localparam int CTRL_BOOT = 8; // shading_boot_slot, 4 bits
  localparam int CTRL_GSEL = 12; // gain_map_slot_select, 3 bits
  localparam int CMD_BUILD = 0; // shading_build_cmd
  localparam int CMD_STORE = 1; // shading_store_cmd
  localparam int CMD_RECALL = 2; // shading_recall_cmd
  localparam int CMD_GBUILD = 3; // gain_map_build_cmd
  localparam int CMD_GSTORE = 4; // gain_map_store_cmd
  localparam int CMD_GRECALL = 5; // gain_map_recall_cmd
  localparam int ST_BUSY = 0; // Copy engine running
  localparam int ST_BLD = 1; // Shading build pending or running
  localparam int ST_GBLD = 2; // Gain build pending or running
  localparam logic [31:0] CTRL_RST = 32'h0000_0000; // Settings at reset
  // ----------------------------------------------------------------
  // Copy engine operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE, OP_SHD_ST, OP_SHD_LD, OP_GN_ST, OP_GN_LD
  } sfc_op_e;
endpackage

// *** verif/sfc_top_props.sv ***
// Port assertions for the shading correction top level
`timescale 1ns/1ps
`default_nettype none
module sfc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pix_in_valid,
  input wire logic pix_in_ready,
  input wire logic pix_in_sof,
  input wire logic [7:0] pix_in_data,
  input wire logic pix_out_valid,
  input wire logic pix_out_ready,
  input wire logic [7:0] pix_out_data
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Only the low address byte is decoded
  logic hit;
  assign hit = paddr[7:0] inside
    {sfc_pkg::REG_CTRL, sfc_pkg::REG_CMD, sfc_pkg::REG_STAT};
  // Pixel accepted by the pipeline
  logic take;
  assign take = pix_in_valid && pix_in_ready;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_setup_answer: assert property (
    psel && !penable |=> pready && penable)
    else $error("no answer in access phase");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_decode: assert property (pready |-> pslverr == !hit)
    else $error("pslverr does not match decode");
  chk_err_zero: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  chk_cmd_zero: assert property (pready && !pwrite &&
    paddr[7:0] == sfc_pkg::REG_CMD |-> prdata == 32'h0000_0000)
    else $error("command register read not zero");
  chk_out_hold: assert property (pix_out_valid && !pix_out_ready
    |=> pix_out_valid && $stable(pix_out_data))
    else $error("stalled output word changed");
  chk_full_refuse: assert property (!pix_in_ready |-> pix_out_valid)
    else $error("input refused with empty buffer");
  chk_pix_latency: assert property (
    take |-> ##[1:4] pix_out_valid)
    else $error("pixel not out within four cycles");
  chk_rst_clear: assert property ($rose(presetn)
    |-> pix_in_ready && !pix_out_valid && !pready && !pslverr)
    else $error("outputs not cleared by reset");
endmodule // sfc_top_chk

bind sfc_top sfc_top_chk chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pix_in_valid(pix_in_valid),
  .pix_in_ready(pix_in_ready), .pix_in_sof(pix_in_sof),
  .pix_in_data(pix_in_data), .pix_out_valid(pix_out_valid),
  .pix_out_ready(pix_out_ready), .pix_out_data(pix_out_data)
);
`default_nettype wire

// *** verif/sfc_pix_model.sv ***
// Sensor pipeline source and stalling sink for the pixel ports
`timescale 1ns/1ps
`default_nettype none
module sfc_pix_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [7:0] level,
  input wire logic stall,
  input wire logic pix_in_ready,
  output logic pix_in_valid,
  output logic pix_in_sof,
  output logic [7:0] pix_in_data,
  output logic pix_out_ready
);
  logic [10:0] idx_ff; // Pixel index in a 64x32 frame
  logic run_ff; // Frame in progress
  logic [7:0] last_ff; // Last level sent
  logic [1:0] tick_ff; // Stall pattern phase
  // ------------------------------------------------------------
  // Frame sequencer: a pixel is held until it is taken
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_ff <= 11'h000;
      run_ff <= 1'b0;
      last_ff <= 8'h00;
      tick_ff <= 2'h0;
    end else begin
      tick_ff <= tick_ff + 2'h1;
      if (go) begin
        run_ff <= 1'b1;
        idx_ff <= 11'h000;
      end else if (run_ff && pix_in_ready) begin
        idx_ff <= idx_ff + 11'h001;
        last_ff <= level;
        // Always a full window from origin zero
        if (idx_ff == 11'h7FF) begin
          run_ff <= 1'b0;
        end
      end
    end
  end
  assign pix_in_valid = run_ff;
  assign pix_in_sof = run_ff && idx_ff == 11'h000;
  // Idle data is inverted so a stale value never looks valid
  assign pix_in_data = run_ff ? level : ~last_ff;
  // Sink takes one word in four while stalling, so the buffer fills
  assign pix_out_ready = !(stall && tick_ff != 2'h0);
endmodule // sfc_pix_model
`default_nettype wire

// *** verif/tb_sfc_top.sv ***
// Self-checking bench for the shading correction top level
`timescale 1ns/1ps
`default_nettype none
module tb_sfc_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pix_in_valid, pix_in_ready, pix_in_sof;
  logic pix_out_valid, pix_out_ready;
  logic [7:0] pix_in_data, pix_out_data;
  logic go = 1'b0;
  logic stall = 1'b0;
  logic [7:0] level = 8'h00;
  logic [7:0] exp_pix = 8'h00; // Expected output level
  int got_n = 0, bad_n = 0, full_n = 0, cyc = 0;
  int errors = 0;
  int samples_checked = 0;
  always #10 pclk = ~pclk;
  sfc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
    .pix_in_sof(pix_in_sof), .pix_in_data(pix_in_data),
    .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
    .pix_out_data(pix_out_data));
  sfc_pix_model peer (.pclk(pclk), .presetn(presetn), .go(go),
    .level(level), .stall(stall), .pix_in_ready(pix_in_ready),
    .pix_in_valid(pix_in_valid), .pix_in_sof(pix_in_sof),
    .pix_in_data(pix_in_data), .pix_out_ready(pix_out_ready));
  // ------------------------------------------------------------
  // Output monitor and hang guard
  // ------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (pix_out_valid === 1'b1 && pix_out_ready === 1'b1) begin
      got_n <= got_n + 1;
      if (pix_out_data !== exp_pix) bad_n <= bad_n + 1;
    end
    if (pix_in_ready === 1'b0) full_n <= full_n + 1;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] x,
                       input string what);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, s, x);
    end
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is high; otherwise only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic e);
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // Status bit check right after a command
  task automatic stat(input logic [31:0] m, input string what);
    logic [31:0] q;
    logic e;
    rd(sfc_pkg::REG_STAT, q, e);
    check(q & m, m, what);
  endtask
  task automatic wait_idle;
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    do begin
      rd(sfc_pkg::REG_STAT, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    check({31'h0, q[0]}, 32'h0, "copy finished");
  endtask
  // One full frame of a flat level; the monitor judges each word
  task automatic frame(input logic [7:0] lvl, input logic [7:0] x,
                       input logic st);
    @(posedge pclk);
    level <= lvl;
    exp_pix <= x;
    stall <= st;
    got_n <= 0;
    bad_n <= 0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (int i = 0; i < 20000 && got_n < 2048; i++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    stall <= 1'b0;
    check(got_n, 32'h800, "pixel count");
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(sfc_pkg::REG_CTRL, q, e);
    check(q, sfc_pkg::CTRL_RST, "ctrl reset");
    rd(8'h0C, q, e);
    check({q[30:0], e}, 32'h1, "unmapped read");
    wr(sfc_pkg::REG_CTRL, 32'h0000_7FF0);
    rd(sfc_pkg::REG_CTRL, q, e);
    check(q, 32'h0000_7FF0, "ctrl fields");
    $display("test regs done");
  endtask
  task automatic t_build;
    wr(sfc_pkg::REG_CTRL, 32'h0);
    wr(sfc_pkg::REG_CMD, 32'h1);
    stat(32'h2, "build pending");
    frame(8'h40, 8'h40, 1'b0);
    check(bad_n, 32'h0, "build frame bypass");
    // Stalled sink also fills the buffer until it refuses
    frame(8'h20, 8'h20, 1'b1);
    check(bad_n, 32'h0, "bypass level");
    check({31'h0, full_n > 0}, 32'h1, "buffer refused");
    wr(sfc_pkg::REG_CTRL, 32'h1);
    frame(8'h20, 8'h40, 1'b0);
    check(bad_n, 32'h0, "flat divide");
    frame(8'h90, 8'hFF, 1'b0);
    check(bad_n, 32'h0, "saturation");
    $display("test build done");
  endtask
  task automatic t_slots;
    wr(sfc_pkg::REG_CTRL, 32'h30);
    wr(sfc_pkg::REG_CMD, 32'h2);
    stat(32'h1, "store busy");
    wait_idle();
    wr(sfc_pkg::REG_CMD, 32'h1);
    frame(8'h80, 8'h80, 1'b0);
    check(bad_n, 32'h0, "second build bypass");
    wr(sfc_pkg::REG_CTRL, 32'h50);
    wr(sfc_pkg::REG_CMD, 32'h2);
    wait_idle();
    wr(sfc_pkg::REG_CTRL, 32'h30);
    wr(sfc_pkg::REG_CMD, 32'h4);
    wait_idle();
    wr(sfc_pkg::REG_CTRL, 32'h31);
    frame(8'h20, 8'h40, 1'b0);
    check(bad_n, 32'h0, "recall slot");
    wr(sfc_pkg::REG_CTRL, 32'h5000);
    wr(sfc_pkg::REG_CMD, 32'h8);
    stat(32'h4, "gain build pending");
    wr(sfc_pkg::REG_CMD, 32'h10);
    stat(32'h1, "gain store busy");
    wait_idle();
    wr(sfc_pkg::REG_CMD, 32'h20);
    stat(32'h1, "gain recall busy");
    wait_idle();
    wr(sfc_pkg::REG_CTRL, 32'h0);
    wr(sfc_pkg::REG_CMD, 32'h1);
    frame(8'h00, 8'h00, 1'b0);
    check(bad_n, 32'h0, "zero build bypass");
    wr(sfc_pkg::REG_CTRL, 32'h1);
    frame(8'h33, 8'h33, 1'b0);
    check(bad_n, 32'h0, "zero flat");
    $display("test slots done");
  endtask
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr(sfc_pkg::REG_CTRL, 32'h1);
    frame(8'h20, 8'h20, 1'b0);
    check(bad_n, 32'h0, "flat lost at reset");
    $display("test reset done");
  endtask
  task automatic report_and_stop;
    $display("Checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_build();
    t_slots();
    t_reset();
    report_and_stop();
  end
endmodule // tb_sfc_top
`default_nettype wire
